// File: rwri_pkg.sv
`default_nettype none
package rwri_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IX_TIMER = 8'h01;
  localparam logic [7:0] IX_PCLOW = 8'h02;
  localparam logic [7:0] IX_STATUS = 8'h03;
  localparam logic [7:0] IX_POINTER = 8'h04;
  localparam logic [7:0] IX_PCHIGH = 8'h0a;
  localparam logic [7:0] IX_IRQCTL = 8'h0b;
  localparam logic [7:0] IX_PFLAGS = 8'h0c;
  localparam logic [7:0] IX_CMPCFG = 8'h1f;
  localparam logic [7:0] IX_OPTCFG = 8'h81;
  localparam logic [7:0] IX_ADIR = 8'h85;
  localparam logic [7:0] IX_BDIR = 8'h86;
  localparam logic [7:0] IX_PENAB = 8'h8c;
  localparam logic [7:0] IX_PWRCTL = 8'h8e;
  localparam logic [7:0] IX_VREF = 8'h9f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_TMO_N = 4;
  localparam int ST_PWD_N = 3;
  localparam int IC_GLB_EN = 7;
  localparam int IC_PERI_EN = 6;
  localparam int IC_TMR_EN = 5;
  localparam int IC_PIN_EN = 4;
  localparam int IC_CHG_EN = 3;
  localparam int PF_CMP_FL = 6;
  localparam int PW_POR_N = 1;
  localparam int PW_BOR_N = 0;
  localparam int SRC_CHG = 0;
  localparam int SRC_PIN = 1;
  localparam int SRC_TMR = 2;
  localparam int SRC_CMP = 3;
  localparam int N_SRC = 4;

  // ---------------------------------------------------------------
  // reset values, masks, vector, responses
  // ---------------------------------------------------------------
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] OPT_RST = 8'hff;
  localparam logic [4:0] ADIR_RST = 5'h1f;
  localparam logic [7:0] BDIR_RST = 8'hff;
  localparam logic [7:0] PFLAG_MASK = 8'h40;
  localparam logic [7:0] VREF_MASK = 8'hef;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    C_NONE, C_POR, C_BOR, C_MASTER_CLEAR_PIN_RUN, C_MASTER_CLEAR_PIN_SLP, C_WDT_RST, C_WDT_WAKE, C_IRQ_WAKE
  } rwri_cause_t;

endpackage : rwri_pkg
`default_nettype wire

// File: rwri_top.sv
// Summary of operation
// (R1) supply too low: full power-on load, pc 0, status 0001 1xxx, power 0x
// (R2) master clear while running: pc 000h, status 000u uuuu, power untouched
// (R3) master clear asleep: pc 0, status 0001 0uuu, power untouched
// (R4) interrupt wake: pc becomes pc+1, status uuu1 0uuu, power untouched
// (R5) interrupt wake with global enable set: run pc+1, then branch to 0004h
// (R6) brown-out clears power bit 0; master clear and watchdog resets leave it
// (R7) comparator wake sets peripheral flag bit 6; other wakes leave it
// (R8) every interrupt wake sets at least one flag naming its source
// (R9) unimplemented bits always read zero
// (R10) condition bits follow the cause; unchanged bits keep their contents
// (R11) global enable is interrupt control bit 7, cleared on every reset
`default_nettype none
module rwri_top (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [rwri_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [rwri_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  input wire logic SUPPLY_LOW_IN,
  input wire logic BROWNOUT_IN,
  input wire logic MASTER_CLEAR_PIN_IN,
  input wire logic WATCHDOG_TIMER_IN,
  input wire logic SLEEP_ENTER_IN,
  input wire logic [rwri_pkg::N_SRC-1:0] IRQ_EVENT_IN,
  input wire logic [rwri_pkg::PC_W-1:0] CUR_PC_IN,
  input wire logic INSTR_DONE_IN,
  output logic PC_LOAD_OUT,
  output logic [rwri_pkg::PC_W-1:0] PC_VALUE_OUT,
  output logic ASLEEP_OUT,
  output logic VECTOR_PEND_OUT,
  output logic [7:0] CORE_STATUS_OUT,
  output logic [1:0] POWER_CONTROL_OUT
);
  import rwri_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [7:0] w_d;
    logic w_s;
    logic b_v;
    logic [1:0] b_r;
    logic r_v;
    logic [7:0] r_d;
    logic [1:0] r_r;
    logic asleep;
    logic vec_pend;
    logic [PC_W-1:0] pc;
    logic pc_ld;
    logic [7:0] status;
    logic [4:0] pchigh;
    logic [7:0] irqctl;
    logic [7:0] pflags;
    logic [7:0] penab;
    logic [5:0] cmpcfg;
    logic [7:0] optcfg;
    logic [4:0] adir;
    logic [7:0] bdir;
    logic [1:0] pwr;
    logic [7:0] vref;
    logic [7:0] timer;
    logic [7:0] pointer;
  } rwri_state_t;

  rwri_state_t st_q;
  rwri_state_t st_d;
  rwri_cause_t cause;
  logic [N_SRC-1:0] src_en;
  logic wake_hit;
  logic [8:0] rd_hit;
  logic [8:0] wr_hit;

  // ---------------------------------------------------------------
  // register read decode
  // ---------------------------------------------------------------
  // returns {hit, data}; a miss answers with a bus error and zero data
  function automatic logic [8:0] rd_reg(input logic [7:0] ix, input rwri_state_t s);
    logic [8:0] r;
    r = 9'h000;
    case (ix)
      IX_TIMER: r = {1'b1, s.timer};
      IX_PCLOW: r = {1'b1, s.pc[7:0]};
      IX_STATUS: r = {1'b1, s.status};
      IX_POINTER: r = {1'b1, s.pointer};
      IX_PCHIGH: r = {1'b1, 3'h0, s.pchigh};
      IX_IRQCTL: r = {1'b1, s.irqctl};
      IX_PFLAGS: r = {1'b1, s.pflags & PFLAG_MASK}; // R9
      IX_CMPCFG: r = {1'b1, 2'h0, s.cmpcfg};
      IX_OPTCFG: r = {1'b1, s.optcfg};
      IX_ADIR: r = {1'b1, 3'h0, s.adir};
      IX_BDIR: r = {1'b1, s.bdir};
      IX_PENAB: r = {1'b1, s.penab & PFLAG_MASK}; // R9
      IX_PWRCTL: r = {1'b1, 6'h00, s.pwr};
      IX_VREF: r = {1'b1, s.vref & VREF_MASK}; // R9
      default: r = 9'h000;
    endcase
    return r;
  endfunction : rd_reg

  // ---------------------------------------------------------------
  // cause selection
  // ---------------------------------------------------------------
  // a wake needs the source's own enable; the global enable only picks the vector
  assign src_en = {st_q.irqctl[IC_PERI_EN] & st_q.penab[PF_CMP_FL], st_q.irqctl[IC_TMR_EN],
                   st_q.irqctl[IC_PIN_EN], st_q.irqctl[IC_CHG_EN]};
  assign wake_hit = st_q.asleep && (|(IRQ_EVENT_IN & src_en));
  assign rd_hit = rd_reg(S_AXI_ARADDR_IN[9:2], st_q);
  assign wr_hit = rd_reg(st_q.aw_a, st_q);

  // heavier causes win: a supply drop overrides any lighter reset
  always_comb
  begin
    cause = C_NONE;
    if (!RST_N_IN || SUPPLY_LOW_IN)
      cause = C_POR; // R1
    else if (BROWNOUT_IN)
      cause = C_BOR;
    else if (MASTER_CLEAR_PIN_IN)
      cause = st_q.asleep ? C_MASTER_CLEAR_PIN_SLP : C_MASTER_CLEAR_PIN_RUN;
    else if (WATCHDOG_TIMER_IN)
      cause = st_q.asleep ? C_WDT_WAKE : C_WDT_RST;
    else if (wake_hit)
      cause = C_IRQ_WAKE;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    if (!RST_N_IN)
      st_d = '0;
    st_d.pc_ld = 1'b0;
    // bus channels: address and data are held until both are present
    if (S_AXI_AWVALID_IN && !st_q.aw_v)
    begin
      st_d.aw_v = 1'b1;
      st_d.aw_a = S_AXI_AWADDR_IN[9:2];
    end
    if (S_AXI_WVALID_IN && !st_q.w_v)
    begin
      st_d.w_v = 1'b1;
      st_d.w_d = S_AXI_WDATA_IN[7:0];
      st_d.w_s = S_AXI_WSTRB_IN[0];
    end
    if (st_q.b_v && S_AXI_BREADY_IN)
      st_d.b_v = 1'b0;
    if (st_q.aw_v && st_q.w_v && !st_q.b_v)
    begin
      st_d.aw_v = 1'b0;
      st_d.w_v = 1'b0;
      st_d.b_v = 1'b1;
      st_d.b_r = wr_hit[8] ? RESP_OKAY : RESP_SLVERR;
      if (st_q.w_s)
      begin
        case (st_q.aw_a)
          IX_TIMER: st_d.timer = st_q.w_d;
          IX_PCLOW:
          begin
            // a write to the low byte jumps, taking the high bits from the latch
            st_d.pc = {st_q.pchigh, st_q.w_d};
            st_d.pc_ld = 1'b1;
          end
          // power-down and time-out bits are read-only for software
          IX_STATUS: st_d.status = {st_q.w_d[7:5], st_q.status[4:3], st_q.w_d[2:0]};
          IX_POINTER: st_d.pointer = st_q.w_d;
          IX_PCHIGH: st_d.pchigh = st_q.w_d[4:0];
          IX_IRQCTL: st_d.irqctl = st_q.w_d;
          IX_PFLAGS: st_d.pflags = st_q.w_d & PFLAG_MASK; // R9
          IX_CMPCFG: st_d.cmpcfg = st_q.w_d[5:0];
          IX_OPTCFG: st_d.optcfg = st_q.w_d;
          IX_ADIR: st_d.adir = st_q.w_d[4:0];
          IX_BDIR: st_d.bdir = st_q.w_d;
          IX_PENAB: st_d.penab = st_q.w_d & PFLAG_MASK; // R9
          IX_PWRCTL: st_d.pwr = st_q.w_d[1:0];
          IX_VREF: st_d.vref = st_q.w_d & VREF_MASK; // R9
          default: st_d.timer = st_q.timer;
        endcase
      end
    end
    if (S_AXI_ARVALID_IN && !st_q.r_v)
    begin
      st_d.r_v = 1'b1;
      st_d.r_d = rd_hit[7:0];
      st_d.r_r = rd_hit[8] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.r_v && S_AXI_RREADY_IN)
      st_d.r_v = 1'b0;
    // after the wake instruction retires, branch to the vector
    if (st_q.vec_pend && INSTR_DONE_IN)
    begin
      st_d.pc = IRQ_VECTOR; // R5
      st_d.pc_ld = 1'b1;
      st_d.vec_pend = 1'b0;
      st_d.irqctl[IC_GLB_EN] = 1'b0;
    end
    if (SLEEP_ENTER_IN)
    begin
      st_d.asleep = 1'b1;
      st_d.status[ST_TMO_N] = 1'b1;
      st_d.status[ST_PWD_N] = 1'b0;
    end
    // flags set after the bus write so a same-cycle clear loses
    for (int i = 0; i < SRC_CMP; i++)
      if (IRQ_EVENT_IN[i])
        st_d.irqctl[i] = 1'b1; // R8
    if (IRQ_EVENT_IN[SRC_CMP])
      st_d.pflags[PF_CMP_FL] = 1'b1; // R7
    // reset and wake loads override everything above
    case (cause)
      C_POR, C_BOR, C_MASTER_CLEAR_PIN_RUN, C_MASTER_CLEAR_PIN_SLP, C_WDT_RST:
      begin
        st_d.pc = '0;
        st_d.pc_ld = 1'b1;
        st_d.asleep = 1'b0;
        st_d.vec_pend = 1'b0;
        st_d.pchigh = 5'h00;
        st_d.irqctl = {7'h00, st_q.irqctl[0]}; // R11
        st_d.pflags = 8'h00;
        st_d.penab = 8'h00;
        st_d.cmpcfg = 6'h00;
        st_d.optcfg = OPT_RST;
        st_d.adir = ADIR_RST;
        st_d.bdir = BDIR_RST;
        st_d.vref = 8'h00;
        st_d.status[7:5] = 3'h0; // R2
      end
      C_WDT_WAKE, C_IRQ_WAKE:
      begin
        st_d.pc = CUR_PC_IN + 13'h0001; // R4
        st_d.pc_ld = 1'b1;
        st_d.asleep = 1'b0;
      end
      default: st_d.asleep = st_d.asleep;
    endcase
    // condition-dependent bits per cause; all others keep their value
    case (cause)
      C_POR:
      begin
        st_d.status = 8'h18; // R1
        st_d.irqctl = 8'h00;
        st_d.pwr = 2'h0; // R1
      end
      C_BOR:
      begin
        st_d.status[4:3] = 2'h3;
        st_d.pwr[PW_BOR_N] = 1'b0; // R6
      end
      C_MASTER_CLEAR_PIN_SLP: st_d.status[4:3] = 2'h2; // R3
      // an awake watchdog reset marks the time-out only; power-down bit is kept
      C_WDT_RST: st_d.status[ST_TMO_N] = 1'b0; // R10
      C_WDT_WAKE: st_d.status[4:3] = 2'h0; // R10
      C_IRQ_WAKE:
      begin
        st_d.status[4:3] = 2'h2; // R4
        st_d.vec_pend = st_q.irqctl[IC_GLB_EN]; // R5
      end
      default: st_d.status = st_d.status;
    endcase
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  // reset is folded into the next-state logic as a power-on cause
  always_ff @(posedge MCLK_IN)
  begin
    st_q <= st_d;
  end

  assign S_AXI_AWREADY_OUT = !st_q.aw_v;
  assign S_AXI_WREADY_OUT = !st_q.w_v;
  assign S_AXI_BVALID_OUT = st_q.b_v;
  assign S_AXI_BRESP_OUT = st_q.b_r;
  assign S_AXI_ARREADY_OUT = !st_q.r_v;
  assign S_AXI_RVALID_OUT = st_q.r_v;
  assign S_AXI_RDATA_OUT = {24'h000000, st_q.r_d};
  assign S_AXI_RRESP_OUT = st_q.r_r;
  assign PC_LOAD_OUT = st_q.pc_ld;
  assign PC_VALUE_OUT = st_q.pc;
  assign ASLEEP_OUT = st_q.asleep;
  assign VECTOR_PEND_OUT = st_q.vec_pend;
  assign CORE_STATUS_OUT = st_q.status;
  assign POWER_CONTROL_OUT = st_q.pwr;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_por_full_load: assert property (SUPPLY_LOW_IN |=> PC_LOAD_OUT && PC_VALUE_OUT == '0 // R1
    && CORE_STATUS_OUT == 8'h18 && POWER_CONTROL_OUT == 2'h0)
    else $error("power-on load wrong");
  a_master_clear_pin_run_load: assert property (cause == C_MASTER_CLEAR_PIN_RUN |=> PC_VALUE_OUT == '0 // R2
    && CORE_STATUS_OUT[7:5] == 3'h0 && CORE_STATUS_OUT[4:0] == $past(CORE_STATUS_OUT[4:0])
    && POWER_CONTROL_OUT == $past(POWER_CONTROL_OUT))
    else $error("running master clear load wrong");
  a_master_clear_pin_sleep_load: assert property (cause == C_MASTER_CLEAR_PIN_SLP |=> PC_VALUE_OUT == '0 // R3
    && CORE_STATUS_OUT[7:3] == 5'h02 && !ASLEEP_OUT
    && POWER_CONTROL_OUT == $past(POWER_CONTROL_OUT))
    else $error("sleeping master clear load wrong");
  a_irq_wake_pc: assert property (cause == C_IRQ_WAKE |=> PC_LOAD_OUT // R4
    && PC_VALUE_OUT == $past(CUR_PC_IN) + 13'h0001 && CORE_STATUS_OUT[4:3] == 2'h2)
    else $error("interrupt wake pc or status wrong");
  a_vector_branch: assert property ((VECTOR_PEND_OUT && INSTR_DONE_IN && cause == C_NONE) // R5
    |=> PC_LOAD_OUT && PC_VALUE_OUT == IRQ_VECTOR && !VECTOR_PEND_OUT
    && !st_q.irqctl[IC_GLB_EN])
    else $error("vector branch missing");
  a_brownout_bit: assert property ((cause == C_BOR |=> !POWER_CONTROL_OUT[PW_BOR_N]) // R6
    and ((cause == C_MASTER_CLEAR_PIN_RUN || cause == C_WDT_RST)
    |=> POWER_CONTROL_OUT == $past(POWER_CONTROL_OUT)))
    else $error("power control bit 0 wrong");
  a_cmp_wake_flag: assert property ((cause == C_IRQ_WAKE && IRQ_EVENT_IN[SRC_CMP]) // R7
    |=> st_q.pflags[PF_CMP_FL])
    else $error("comparator flag not set on wake");
  a_wake_flag_set: assert property (cause == C_IRQ_WAKE // R8
    |=> (|st_q.irqctl[2:0]) || st_q.pflags[PF_CMP_FL])
    else $error("wake left no flag");
  a_unimpl_zero: assert property ((S_AXI_RVALID_OUT && $past(S_AXI_ARADDR_IN[9:2]) // R9
    == IX_VREF && $rose(S_AXI_RVALID_OUT)) |-> S_AXI_RDATA_OUT[4] == 1'b0)
    else $error("unimplemented bit read as one");
  a_wake_keeps_cfg: assert property (cause == C_WDT_WAKE |=> // R10
    st_q.optcfg == $past(st_q.optcfg) && st_q.bdir == $past(st_q.bdir)
    && CORE_STATUS_OUT[4:3] == 2'h0)
    else $error("watchdog wake disturbed kept bits");
  a_glb_en_reset: assert property ((cause inside {C_BOR, C_MASTER_CLEAR_PIN_RUN, C_WDT_RST}) // R11
    |=> !st_q.irqctl[IC_GLB_EN] && !st_q.vec_pend)
    else $error("global enable survived reset");

endmodule : rwri_top
`default_nettype wire

// File: rwri_top_bench.sv
`default_nettype none
module rwri_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rwri_pkg::*;
  // ------------------------------------------------------------
  // stimulus, design and tables
  // ------------------------------------------------------------
  logic clk, rst_n, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv, pl, slp, vp;
  logic [9:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [3:0] ws, irq;
  logic [1:0] br, rr, pw;
  logic [5:0] cz; // done, supply, brownout, clear, watchdog, sleep
  logic [12:0] cpc, pcv;
  logic [7:0] cst, st, d, en;
  int fail_count, num_checks, cyc, seed;
  localparam logic [7:0] RIX [10] = '{IX_OPTCFG, IX_ADIR, IX_BDIR, IX_STATUS, IX_PWRCTL,
    IX_IRQCTL, IX_PFLAGS, IX_PENAB, IX_CMPCFG, IX_VREF};
  localparam logic [7:0] RVL [10] = '{8'hff, 8'h1f, 8'hff, 8'h18, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MIX [6] = '{IX_VREF, IX_PFLAGS, IX_PENAB, IX_CMPCFG, IX_PCHIGH, IX_ADIR};
  localparam logic [7:0] MVL [6] = '{8'hef, 8'h40, 8'h40, 8'h3f, 8'h1f, 8'h1f};
  localparam logic [7:0] UIX [4] = '{8'h00, 8'h05, 8'h06, 8'h20};

  rwri_top rwri_top_i (.MCLK_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrdy), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry), .S_AXI_BRESP_OUT(br),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .S_AXI_RDATA_OUT(rdt),
    .S_AXI_RRESP_OUT(rr), .SUPPLY_LOW_IN(cz[4]), .BROWNOUT_IN(cz[3]),
    .MASTER_CLEAR_PIN_IN(cz[2]), .WATCHDOG_TIMER_IN(cz[1]), .SLEEP_ENTER_IN(cz[0]),
    .IRQ_EVENT_IN(irq), .CUR_PC_IN(cpc), .INSTR_DONE_IN(cz[5]), .PC_LOAD_OUT(pl),
    .PC_VALUE_OUT(pcv), .ASLEEP_OUT(slp), .VECTOR_PEND_OUT(vp), .CORE_STATUS_OUT(cst),
    .POWER_CONTROL_OUT(pw));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wrap_up;
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] ix, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    awv <= 1;
    wv <= 1;
    bry <= 1;
    awa <= {ix, 2'b00};
    wd <= {24'h0, v};
    forever
    begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
      if (bry && bv)
      begin
        bry <= 0;
        chk("bresp", 32'(br), 32'(er));
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] ix, output logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    arv <= 1;
    rry <= 1;
    ara <= {ix, 2'b00};
    forever
    begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rry && rv)
      begin
        rry <= 0;
        v = rdt[7:0];
        chk("rresp", 32'(rr), 32'(er));
        chk("rdata_upper", 32'(rdt[31:8]), 32'h0);
        break;
      end
    end
  endtask : rd

  task automatic rc(input logic [7:0] ix, input logic [7:0] e);
    logic [7:0] v;
    rd(ix, v, RESP_OKAY);
    chk($sformatf("reg_%h", ix), 32'(v), 32'(e));
  endtask : rc

  // one-cycle cause pulse; returns just after the edge that answers it
  task automatic ev(input logic [5:0] c, input logic [3:0] q);
    @(posedge clk);
    cz <= c;
    irq <= q;
    @(posedge clk);
    cz <= 6'h00;
    irq <= 4'h0;
    #1;
  endtask : ev

  task automatic post(input logic [12:0] p, input logic [7:0] s, input logic [1:0] w);
    chk("pc_load", 32'(pl), 32'h1);
    chk("pc_value", 32'(pcv), 32'(p));
    chk("status", 32'(cst), 32'(s));
    chk("power", 32'(pw), 32'(w));
  endtask : post

  // expected status per cause, unchanged bits carried from the old value
  function automatic logic [7:0] xs(input int c, input logic [7:0] o);
    case (c)
      1: return {3'b000, 2'b11, o[2:0]};
      2: return {3'b000, o[4:0]};
      3: return {3'b000, 2'b10, o[2:0]};
      4: return {3'b000, 1'b0, o[3:0]};
      5: return {o[7:5], 2'b00, o[2:0]};
      default: return {o[7:5], 2'b10, o[2:0]};
    endcase
  endfunction : xs

  // ------------------------------------------------------------
  // clock, timeout, sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  // a hang ends the run as a failure instead of spinning forever
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    seed = 22922;
    {rst_n, awv, wv, bry, arv, rry} = '0;
    {awa, ara, wd, cz, irq, cpc} = '0;
    ws = 4'h1;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 10; i++) rc(RIX[i], RVL[i]);
    for (int i = 0; i < 6; i++)
    begin
      wr(MIX[i], 8'hff, RESP_OKAY);
      rc(MIX[i], MVL[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(UIX[i], 8'h5a, RESP_SLVERR);
      rd(UIX[i], d, RESP_SLVERR);
      chk("unmapped", 32'(d), 32'h0);
    end
    ws <= 4'h0;
    wr(IX_OPTCFG, 8'h00, RESP_OKAY);
    ws <= 4'h1;
    rc(IX_OPTCFG, 8'hff);
    st = 8'h18;
    // random status contents through clear, brown-out, supply loss and watchdog reset
    for (int i = 0; i < 4; i++)
    begin
      cpc <= 13'($random(seed));
      d = 8'($random(seed));
      wr(IX_STATUS, d, RESP_OKAY);
      st = {d[7:5], st[4:3], d[2:0]};
      rc(IX_STATUS, st);
      wr(IX_PWRCTL, 8'h03, RESP_OKAY);
      wr(IX_IRQCTL, 8'h81, RESP_OKAY);
      ev(6'h04, 4'h0);
      st = xs(2, st);
      post(13'h0, st, 2'b11);
      rc(IX_IRQCTL, 8'h01);
      ev(6'h08, 4'h0);
      st = xs(1, st);
      post(13'h0, st, 2'b10);
      ev(6'h10, 4'h0);
      st = 8'h18;
      post(13'h0, st, 2'b00);
      ev(6'h02, 4'h0);
      st = xs(4, st);
      post(13'h0, st, 2'b00);
    end
    ev(6'h01, 4'h0);
    chk("asleep", 32'(slp), 32'h1);
    ev(6'h04, 4'h0);
    st = xs(3, st);
    post(13'h0, st, 2'b00);
    // every wake source with the global enable set
    for (int s = 0; s < N_SRC; s++)
    begin
      en = (s == SRC_CMP) ? 8'h40 : 8'(8'h08 << s);
      wr(IX_IRQCTL, 8'h80 | en, RESP_OKAY);
      wr(IX_PENAB, 8'h40, RESP_OKAY);
      wr(IX_PFLAGS, 8'h00, RESP_OKAY);
      cpc <= 13'($random(seed));
      ev(6'h01, 4'h0);
      ev(6'h00, 4'(1 << s));
      st = xs(6, st);
      post(cpc + 13'h1, st, 2'b00);
      chk("asleep_vector", 32'({slp, vp}), 32'h1);
      rc(IX_PFLAGS, (s == SRC_CMP) ? 8'h40 : 8'h00);
      ev(6'h20, 4'h0);
      post(IRQ_VECTOR, st, 2'b00);
      chk("vector_pend", 32'(vp), 32'h0);
      rc(IX_IRQCTL, en | ((s == SRC_CMP) ? 8'h00 : 8'(1 << s)));
    end
    cpc <= 13'($random(seed));
    ev(6'h01, 4'h0);
    ev(6'h02, 4'h0);
    st = xs(5, st);
    post(cpc + 13'h1, st, 2'b00);
    chk("vector_pend", 32'(vp), 32'h0);
    wr(IX_IRQCTL, 8'h00, RESP_OKAY);
    ev(6'h01, 4'h0);
    ev(6'h00, 4'hf);
    chk("masked_wake", 32'({slp, pl}), 32'h2);
    ev(6'h04, 4'h0);
    post(13'h0, xs(3, st), 2'b00);
    wrap_up();
  end
endmodule : rwri_top_bench
`default_nettype wire
